// ---- hw/aam_pkg.sv ----
package aam_pkg;

   // ==========================================================
   // register map (byte addresses, one word each)
   localparam int unsigned AAM_ADDR_W     = 8;
   localparam logic [7:0]  ADDR_ARP_CFG   = 8'h00;
   localparam logic [7:0]  ADDR_IP_CFG    = 8'h04;
   localparam logic [7:0]  ADDR_SRC_ADDR  = 8'h08;
   localparam logic [7:0]  ADDR_SRC_MASK  = 8'h0C;
   localparam logic [7:0]  ADDR_STATUS    = 8'h10;
   localparam logic [7:0]  ADDR_CTRL      = 8'h14;

   // ==========================================================
   // field positions
   localparam int unsigned ARP_LEN_LSB    = 0;
   localparam int unsigned ARP_HRD_LSB    = 2;
   localparam int unsigned ARP_PRO_LSB    = 4;
   localparam int unsigned IP_MODE_LSB    = 0;
   localparam int unsigned IP_VAL_LSB     = 8;
   localparam int unsigned IP_TTL_LSB     = 16;
   localparam int unsigned IP_FRAG_LSB    = 18;
   localparam int unsigned IP_OPT_LSB     = 20;
   localparam int unsigned IP_SRC_LSB     = 24;
   localparam int unsigned CTRL_EN_BIT    = 0;
   localparam int unsigned CTRL_CLR_BIT   = 1;
   localparam int unsigned ST_LAST_BIT    = 0;
   localparam int unsigned ST_CNT_LSB     = 16;
   localparam int unsigned ST_CNT_MAX_W   = 16;

   // ==========================================================
   // reset values and protocol constants
   localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;
   localparam logic [31:0] MASK_RESET     = 32'hFFFF_FFFF;
   localparam logic [7:0]  ARP_HLN_ETH    = 8'h06;
   localparam logic [7:0]  ARP_PLN_IPV4   = 8'h04;
   localparam logic [15:0] ARP_HRD_ETH    = 16'h0001;
   localparam logic [15:0] ARP_PRO_IP     = 16'h0800;
   localparam logic [7:0]  IPPROTO_ICMP   = 8'h01;
   localparam logic [7:0]  IPPROTO_TCP    = 8'h06;
   localparam logic [7:0]  IPPROTO_UDP    = 8'h11;
   localparam logic [3:0]  IPV4_MIN_IHL   = 4'h5;
   localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      TRI_ANY   = 2'b00,
      TRI_FALSE = 2'b01,
      TRI_TRUE  = 2'b10
   } aam_tri_t;

   typedef enum logic [2:0] {
      PROTO_ANY      = 3'b000,
      PROTO_SPECIFIC = 3'b001,
      PROTO_ICMP     = 3'b010,
      PROTO_UDP      = 3'b011,
      PROTO_TCP      = 3'b100
   } aam_proto_mode_t;

   typedef enum logic [1:0] {
      SRC_ANY     = 2'b00,
      SRC_HOST    = 2'b01,
      SRC_NETWORK = 2'b10
   } aam_src_mode_t;

   typedef enum logic [1:0] {
      SUB_NONE = 2'b00,
      SUB_ICMP = 2'b01,
      SUB_UDP  = 2'b10,
      SUB_TCP  = 2'b11
   } aam_sub_t;

   // parsed header from the ingress parser
   typedef struct packed {
      logic        valid;
      logic        is_arp;
      logic        is_ipv4;
      logic [7:0]  arp_hln;
      logic [7:0]  arp_pln;
      logic [15:0] arp_hrd;
      logic [15:0] arp_pro;
      logic [7:0]  ip_proto;
      logic [7:0]  ip_ttl;
      logic        ip_mf;
      logic [12:0] ip_frag_off;
      logic [3:0]  ip_ihl;
      logic [31:0] source_ipv4_address;
   } aam_hdr_t;

   // match result to the action logic
   typedef struct packed {
      logic     valid;
      logic     hit;
      aam_sub_t sub_check;
   } aam_result_t;

   typedef struct packed {
      logic            enable;
      aam_tri_t        arp_len;
      aam_tri_t        arp_hrd;
      aam_tri_t        arp_pro;
      aam_proto_mode_t proto_mode;
      logic [7:0]      proto_val;
      aam_tri_t        ttl;
      aam_tri_t        frag;
      aam_tri_t        opt;
      aam_src_mode_t   src_mode;
      logic [31:0]     source_ipv4_address;
      logic [31:0]     source_ipv4_netmask;
   } aam_cfg_t;

endpackage : aam_pkg

// ---- hw/aam_matcher.sv ----
// Summary of operation
// - length condition checks hln 0x06, pln 0x04
// - hardware space condition checks hrd equals 1
// - protocol space condition checks pro 0x800
// - don't-care setting never restricts a match
// - protocol don't-care skips the protocol field
// - specific protocol equals configured 8-bit number
// - icmp mode needs icmp, flags icmp checks
// - udp mode needs udp, flags udp checks
// - tcp mode needs tcp, flags tcp checks
// - ttl zero rejects nonzero ttl frames
// - ttl non-zero accepts ttl above zero
// - fragment no rejects mf or offset frames
// - fragment yes accepts mf or offset frames
// - options no rejects frames with options
// - options yes accepts frames with options
// - source don't-care skips source address
// - host mode needs exact source address
// - network mode compares address under mask
//
// The placing of the registers and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ns

module aam_matcher
   import aam_pkg::*;
#(
   parameter int unsigned COUNT_W = 16
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // parser side
   input  wire aam_hdr_t    hdr_in,
   // action side
   output aam_result_t      result_out
);

   // ==========================================================
   // parameter check
   if (COUNT_W < 1 || COUNT_W > ST_CNT_MAX_W) begin : g_bad_count_w
      $error("aam_matcher: COUNT_W out of range");
   end

   // ==========================================================
   // state
   typedef struct packed {
      aam_cfg_t               cfg;
      logic                   wr_pend;
      logic [AAM_ADDR_W-1:0]  wr_addr;
      logic [31:0]            rdata;
      logic                   ready;
      logic                   resp;
      aam_result_t            result;
      logic                   last_hit;
      logic [COUNT_W-1:0]     hit_cnt;
   } aam_state_t;

   aam_state_t s_q;
   aam_state_t s_d;

   // ==========================================================
   // helpers
   function automatic logic tri_ok(input aam_tri_t cond, input logic fact);
      logic ok;
      ok = 1'b1;
      case (cond)
         TRI_TRUE:  ok = fact;
         TRI_FALSE: ok = !fact;
         default:   ok = 1'b1;
      endcase
      return ok;
   endfunction : tri_ok

   // codes 00 and 11 are both don't-care, so only the two set codes restrict
   function automatic logic tri_set(input aam_tri_t cond);
      return (cond == TRI_TRUE) || (cond == TRI_FALSE);
   endfunction : tri_set

   function automatic logic [31:0] rd_word(input logic [AAM_ADDR_W-1:0] a,
                                           input aam_state_t st);
      logic [31:0] w;
      w = WORD_ZERO;
      case (a)
         ADDR_ARP_CFG: begin
            w[ARP_LEN_LSB +: 2] = st.cfg.arp_len;
            w[ARP_HRD_LSB +: 2] = st.cfg.arp_hrd;
            w[ARP_PRO_LSB +: 2] = st.cfg.arp_pro;
         end
         ADDR_IP_CFG: begin
            w[IP_MODE_LSB +: 3] = st.cfg.proto_mode;
            w[IP_VAL_LSB +: 8]  = st.cfg.proto_val;
            w[IP_TTL_LSB +: 2]  = st.cfg.ttl;
            w[IP_FRAG_LSB +: 2] = st.cfg.frag;
            w[IP_OPT_LSB +: 2]  = st.cfg.opt;
            w[IP_SRC_LSB +: 2]  = st.cfg.src_mode;
         end
         ADDR_SRC_ADDR: w = st.cfg.source_ipv4_address;
         ADDR_SRC_MASK: w = st.cfg.source_ipv4_netmask;
         ADDR_STATUS: begin
            w[ST_LAST_BIT]            = st.last_hit;
            w[ST_CNT_LSB +: COUNT_W]  = st.hit_cnt;
         end
         ADDR_CTRL: w[CTRL_EN_BIT] = st.cfg.enable;
         default:   w = WORD_ZERO;
      endcase
      return w;
   endfunction : rd_word

   // ==========================================================
   // match terms
   logic     arp_len_fact;
   logic     arp_hrd_fact;
   logic     arp_pro_fact;
   logic     ttl_fact;
   logic     frag_fact;
   logic     opt_fact;
   logic     arp_need;
   logic     ip_need;
   logic     arp_ok;
   logic     proto_ok;
   logic     src_ok;
   logic     ip_ok;
   logic     hit;
   aam_sub_t sub;

   always_comb begin
      arp_len_fact = (hdr_in.arp_hln == ARP_HLN_ETH)
                     && (hdr_in.arp_pln == ARP_PLN_IPV4);
      arp_hrd_fact = (hdr_in.arp_hrd == ARP_HRD_ETH);
      arp_pro_fact = (hdr_in.arp_pro == ARP_PRO_IP);
      ttl_fact     = (hdr_in.ip_ttl != 8'h00);
      frag_fact    = hdr_in.ip_mf || (hdr_in.ip_frag_off != 13'h0000);
      opt_fact     = (hdr_in.ip_ihl > IPV4_MIN_IHL);

      // a set condition needs a frame of its family; unused codes stay don't-care
      arp_need = tri_set(s_q.cfg.arp_len) || tri_set(s_q.cfg.arp_hrd)
                 || tri_set(s_q.cfg.arp_pro);
      ip_need  = (s_q.cfg.proto_mode inside {PROTO_SPECIFIC, PROTO_ICMP, PROTO_UDP, PROTO_TCP})
                 || tri_set(s_q.cfg.ttl) || tri_set(s_q.cfg.frag) || tri_set(s_q.cfg.opt)
                 || (s_q.cfg.src_mode inside {SRC_HOST, SRC_NETWORK});

      arp_ok = tri_ok(s_q.cfg.arp_len, arp_len_fact)
               && tri_ok(s_q.cfg.arp_hrd, arp_hrd_fact)
               && tri_ok(s_q.cfg.arp_pro, arp_pro_fact)
               && (!arp_need || hdr_in.is_arp);

      proto_ok = 1'b1;
      sub      = SUB_NONE;
      case (s_q.cfg.proto_mode)
         PROTO_ANY: proto_ok = 1'b1;
         PROTO_SPECIFIC: proto_ok = (hdr_in.ip_proto == s_q.cfg.proto_val);
         PROTO_ICMP: begin
            proto_ok = (hdr_in.ip_proto == IPPROTO_ICMP);
            sub      = SUB_ICMP;
         end
         PROTO_UDP: begin
            proto_ok = (hdr_in.ip_proto == IPPROTO_UDP);
            sub      = SUB_UDP;
         end
         PROTO_TCP: begin
            proto_ok = (hdr_in.ip_proto == IPPROTO_TCP);
            sub      = SUB_TCP;
         end
         default: proto_ok = 1'b1;
      endcase

      src_ok = 1'b1;
      case (s_q.cfg.src_mode)
         SRC_ANY: src_ok = 1'b1;
         SRC_HOST: src_ok = (hdr_in.source_ipv4_address
                             == s_q.cfg.source_ipv4_address);
         SRC_NETWORK: src_ok = ((hdr_in.source_ipv4_address
                                 & s_q.cfg.source_ipv4_netmask)
                                == (s_q.cfg.source_ipv4_address
                                    & s_q.cfg.source_ipv4_netmask));
         default: src_ok = 1'b1;
      endcase

      ip_ok = proto_ok && src_ok
              && tri_ok(s_q.cfg.ttl, ttl_fact)
              && tri_ok(s_q.cfg.frag, frag_fact)
              && tri_ok(s_q.cfg.opt, opt_fact)
              && (!ip_need || hdr_in.is_ipv4);

      hit = s_q.cfg.enable && arp_ok && ip_ok;
   end

   // ==========================================================
   // next state
   logic                  addr_take;
   logic [AAM_ADDR_W-1:0] a_addr;
   logic                  clr_cnt;

   always_comb begin
      s_d       = s_q;
      addr_take = hsel && hready && (htrans == HTRANS_NONSEQ);
      a_addr    = haddr[AAM_ADDR_W-1:0];
      clr_cnt   = 1'b0;

      // write data phase: apply hwdata to the address captured last address phase
      if (s_q.wr_pend) begin
         case (s_q.wr_addr)
            ADDR_ARP_CFG: begin
               s_d.cfg.arp_len = aam_tri_t'(hwdata[ARP_LEN_LSB +: 2]);
               s_d.cfg.arp_hrd = aam_tri_t'(hwdata[ARP_HRD_LSB +: 2]);
               s_d.cfg.arp_pro = aam_tri_t'(hwdata[ARP_PRO_LSB +: 2]);
            end
            ADDR_IP_CFG: begin
               s_d.cfg.proto_mode = aam_proto_mode_t'(hwdata[IP_MODE_LSB +: 3]);
               s_d.cfg.proto_val  = hwdata[IP_VAL_LSB +: 8];
               s_d.cfg.ttl        = aam_tri_t'(hwdata[IP_TTL_LSB +: 2]);
               s_d.cfg.frag       = aam_tri_t'(hwdata[IP_FRAG_LSB +: 2]);
               s_d.cfg.opt        = aam_tri_t'(hwdata[IP_OPT_LSB +: 2]);
               s_d.cfg.src_mode   = aam_src_mode_t'(hwdata[IP_SRC_LSB +: 2]);
            end
            ADDR_SRC_ADDR: s_d.cfg.source_ipv4_address = hwdata;
            ADDR_SRC_MASK: s_d.cfg.source_ipv4_netmask = hwdata;
            ADDR_CTRL: begin
               s_d.cfg.enable = hwdata[CTRL_EN_BIT];
               clr_cnt        = hwdata[CTRL_CLR_BIT];
            end
            default: s_d.cfg = s_q.cfg;
         endcase
      end

      // match pipeline: one registered stage, result is a one-cycle pulse
      s_d.result.valid     = hdr_in.valid;
      s_d.result.hit       = hdr_in.valid && hit;
      s_d.result.sub_check = hdr_in.valid ? sub : SUB_NONE;
      if (hdr_in.valid) begin
         s_d.last_hit = hit;
      end

      // a hit in the clearing cycle still counts, so no event is lost
      if (clr_cnt) begin
         s_d.hit_cnt = '0;
      end
      if (hdr_in.valid && hit && (s_d.hit_cnt != '1)) begin
         s_d.hit_cnt = s_d.hit_cnt + COUNT_W'(1);
      end

      // reads come from the updated copy, so a write just before is seen
      s_d.wr_pend = addr_take && hwrite;
      s_d.wr_addr = addr_take ? a_addr : s_q.wr_addr;
      if (addr_take && !hwrite) begin
         s_d.rdata = rd_word(a_addr, s_d);
      end else begin
         s_d.rdata = WORD_ZERO;
      end
      s_d.ready = 1'b1;
      s_d.resp  = 1'b0;
   end

   // ==========================================================
   // registers
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_q.cfg.enable              <= 1'b0;
         s_q.cfg.arp_len             <= TRI_ANY;
         s_q.cfg.arp_hrd             <= TRI_ANY;
         s_q.cfg.arp_pro             <= TRI_ANY;
         s_q.cfg.proto_mode          <= PROTO_ANY;
         s_q.cfg.proto_val           <= 8'h00;
         s_q.cfg.ttl                 <= TRI_ANY;
         s_q.cfg.frag                <= TRI_ANY;
         s_q.cfg.opt                 <= TRI_ANY;
         s_q.cfg.src_mode            <= SRC_ANY;
         s_q.cfg.source_ipv4_address <= WORD_ZERO;
         s_q.cfg.source_ipv4_netmask <= MASK_RESET;
         s_q.wr_pend                 <= 1'b0;
         s_q.wr_addr                 <= '0;
         s_q.rdata                   <= WORD_ZERO;
         s_q.ready                   <= 1'b1;
         s_q.resp                    <= 1'b0;
         s_q.result                  <= '0;
         s_q.last_hit                <= 1'b0;
         s_q.hit_cnt                 <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // outputs, all from flops; never wait states, always okay
   assign hrdata     = s_q.rdata;
   assign hreadyout  = s_q.ready;
   assign hresp      = s_q.resp;
   assign result_out = s_q.result;

endmodule : aam_matcher

// ---- testbench/aam_matcher_asserts.sv ----
`timescale 1ns/1ns
module aam_matcher_asserts
   import aam_pkg::*;
#(
   parameter int unsigned COUNT_W = 16
) (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        resetn,
   // bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // frame side
   input wire aam_hdr_t    hdr_in,
   input wire aam_result_t result_out
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // ==========================================================
   // read data phase marker
   logic rd_q;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) rd_q <= 1'b0;
      else rd_q <= hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
   end
   // ==========================================================
   // properties
   chk_res_follow: assert property (hdr_in.valid |=> result_out.valid)
      else $error("result missing after header");
   chk_res_cause: assert property (result_out.valid |-> $past(hdr_in.valid))
      else $error("result without header");
   chk_idle_quiet: assert property (!result_out.valid |->
      !result_out.hit && result_out.sub_check == SUB_NONE)
      else $error("result fields set while idle");
   chk_icmp_hit: assert property (result_out.hit && result_out.sub_check == SUB_ICMP |->
      $past(hdr_in.is_ipv4) && $past(hdr_in.ip_proto) == IPPROTO_ICMP)
      else $error("icmp hit on other protocol");
   chk_udp_hit: assert property (result_out.hit && result_out.sub_check == SUB_UDP |->
      $past(hdr_in.is_ipv4) && $past(hdr_in.ip_proto) == IPPROTO_UDP)
      else $error("udp hit on other protocol");
   chk_tcp_hit: assert property (result_out.hit && result_out.sub_check == SUB_TCP |->
      $past(hdr_in.is_ipv4) && $past(hdr_in.ip_proto) == IPPROTO_TCP)
      else $error("tcp hit on other protocol");
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   chk_rdata_idle: assert property (hrdata != 32'h0000_0000 |-> rd_q)
      else $error("read data outside read phase");
endmodule : aam_matcher_asserts

bind aam_matcher aam_matcher_asserts #(.COUNT_W(COUNT_W)) u_chk (.sys_clk(sys_clk),
   .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .hdr_in(hdr_in), .result_out(result_out));

// ---- testbench/aam_parser_model.sv ----
`timescale 1ns/1ns
module aam_parser_model
   import aam_pkg::*;
(
   // clock and reset
   input  wire logic     sys_clk,
   input  wire logic     resetn,
   // request from bench
   input  wire logic     go,
   input  wire aam_hdr_t req,
   // header toward matcher
   output aam_hdr_t      hdr_in
);
   // ==========================================================
   // fields outside a pulse are scrambled so stale values never help
   aam_hdr_t idle_hdr;
   always_comb begin
      idle_hdr       = ~hdr_in;
      idle_hdr.valid = 1'b0;
   end
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         hdr_in <= '0;
      end else if (go) begin
         hdr_in <= req;
      end else begin
         hdr_in <= idle_hdr;
      end
   end
endmodule : aam_parser_model

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ns
module tb_top import aam_pkg::*;;
   // ==========================================================
   // signals
   localparam int CW = 4;
   logic        sys_clk, resetn, hsel, hwrite, go, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd, iw, r;
   logic [1:0]  htrans;
   aam_hdr_t    hdr_in, req, h1, h2;
   aam_result_t result_out, e1, e2;
   aam_cfg_t    c;
   int          err_count, n_tests, cyc, cnt;
   int          seed = 32'h0000_03c3;
   logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
   logic [31:0] rv [7] = '{0, 0, 0, 32'hFFFF_FFFF, 0, 0, 0};

   aam_matcher #(.COUNT_W(CW)) uut (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .hdr_in(hdr_in), .result_out(result_out));
   aam_parser_model u_src (.sys_clk(sys_clk), .resetn(resetn), .go(go), .req(req),
      .hdr_in(hdr_in));

   initial sys_clk = 1'b0;
   always #20 sys_clk = ~sys_clk;
   // ==========================================================
   // helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   // entered just after a rising edge; waits on hready with no fixed latency
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {24'h00_0000, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   function automatic logic tri_ok(aam_tri_t t, logic cond, logic kind);
      return (t == TRI_FALSE) ? kind && !cond : (t == TRI_TRUE) ? kind && cond : 1'b1;
   endfunction : tri_ok
   function automatic aam_result_t exp_res(aam_cfg_t k, aam_hdr_t h);
      logic ok;
      ok = k.enable;
      ok &= tri_ok(k.arp_len, h.arp_hln == ARP_HLN_ETH && h.arp_pln == ARP_PLN_IPV4, h.is_arp);
      ok &= tri_ok(k.arp_hrd, h.arp_hrd == ARP_HRD_ETH, h.is_arp);
      ok &= tri_ok(k.arp_pro, h.arp_pro == ARP_PRO_IP, h.is_arp);
      ok &= tri_ok(k.ttl, h.ip_ttl != 8'h00, h.is_ipv4);
      ok &= tri_ok(k.frag, h.ip_mf || h.ip_frag_off != 13'h0000, h.is_ipv4);
      ok &= tri_ok(k.opt, h.ip_ihl > IPV4_MIN_IHL, h.is_ipv4);
      case (k.proto_mode)
         PROTO_SPECIFIC: ok &= h.is_ipv4 && h.ip_proto == k.proto_val;
         PROTO_ICMP:     ok &= h.is_ipv4 && h.ip_proto == IPPROTO_ICMP;
         PROTO_UDP:      ok &= h.is_ipv4 && h.ip_proto == IPPROTO_UDP;
         PROTO_TCP:      ok &= h.is_ipv4 && h.ip_proto == IPPROTO_TCP;
         default:        ok &= 1'b1;
      endcase
      if (k.src_mode == SRC_HOST)
         ok &= h.is_ipv4 && h.source_ipv4_address == k.source_ipv4_address;
      if (k.src_mode == SRC_NETWORK)
         ok &= h.is_ipv4 && ((h.source_ipv4_address ^ k.source_ipv4_address)
               & k.source_ipv4_netmask) == 32'h0000_0000;
      return '{valid: 1'b1, hit: ok, sub_check: k.proto_mode == PROTO_ICMP ? SUB_ICMP :
               k.proto_mode == PROTO_UDP ? SUB_UDP :
               k.proto_mode == PROTO_TCP ? SUB_TCP : SUB_NONE};
   endfunction : exp_res
   // biased towards the configured values so hits are not rare
   task automatic mk(output aam_hdr_t h);
      logic [31:0] a, b;
      a = $random(seed);
      b = $random(seed);
      h.valid       = 1'b1;
      h.is_arp      = a[0];
      h.is_ipv4     = a[1];
      h.arp_hln     = a[2] ? ARP_HLN_ETH : b[7:0];
      h.arp_pln     = a[3] ? ARP_PLN_IPV4 : b[15:8];
      h.arp_hrd     = a[4] ? ARP_HRD_ETH : b[15:0];
      h.arp_pro     = a[5] ? ARP_PRO_IP : b[31:16];
      h.ip_proto    = a[7] ? (a[6] ? c.proto_val : IPPROTO_ICMP)
                           : (a[6] ? IPPROTO_UDP : IPPROTO_TCP);
      h.ip_ttl      = a[8] ? 8'h00 : b[7:0];
      h.ip_mf       = a[9] & b[0];
      h.ip_frag_off = a[10] ? 13'h0000 : b[28:16];
      h.ip_ihl      = a[11] ? IPV4_MIN_IHL : b[11:8];
      h.source_ipv4_address = a[12] ? c.source_ipv4_address ^
         (a[13] ? 32'h0000_0000 : b & ~c.source_ipv4_netmask) : b;
   endtask : mk
   // ==========================================================
   // timeout and main sequence
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         conclude();
      end
   end
   initial begin
      {resetn, hsel, hwrite, go, haddr, hwdata, htrans, req} = '0;
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      bus(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
      bus(1'b1, 8'h18, 32'hFFFF_FFFF);
      for (int i = 0; i < 7; i++) begin
         bus(1'b0, ra[i], 32'h0000_0000);
         chk(rd, rv[i]);
      end
      $display("test registers done");
      for (int i = 0; i < 300; i++) begin
         r = $random(seed);
         c.enable     = r[31:28] != 4'h0;
         c.arp_len    = aam_tri_t'(r[0] ? 2'h0 : r[2:1]);
         c.arp_hrd    = aam_tri_t'(r[3] ? 2'h0 : r[5:4]);
         c.arp_pro    = aam_tri_t'(r[6] ? 2'h0 : r[8:7]);
         c.ttl        = aam_tri_t'(r[9] ? 2'h0 : r[11:10]);
         c.frag       = aam_tri_t'(r[12] ? 2'h0 : r[14:13]);
         c.opt        = aam_tri_t'(r[15] ? 2'h0 : r[17:16]);
         c.proto_mode = aam_proto_mode_t'(r[18] ? 3'h0 : r[21:19]);
         c.src_mode   = aam_src_mode_t'(r[22] ? 2'h0 : r[24:23]);
         r = $random(seed);
         c.proto_val  = r[7:0];
         c.source_ipv4_address = $random(seed);
         c.source_ipv4_netmask = $random(seed);
         iw = {6'h00, c.src_mode, 2'h0, c.opt, c.frag, c.ttl, c.proto_val, 5'h00, c.proto_mode};
         bus(1'b1, ADDR_ARP_CFG, {26'h000_0000, c.arp_pro, c.arp_hrd, c.arp_len});
         bus(1'b1, ADDR_IP_CFG, iw);
         bus(1'b1, ADDR_SRC_ADDR, c.source_ipv4_address);
         bus(1'b1, ADDR_SRC_MASK, c.source_ipv4_netmask);
         bus(1'b1, ADDR_CTRL, {30'h0, i % 40 == 0, c.enable});
         if (i % 40 == 0) cnt = 0;
         bus(1'b0, ADDR_IP_CFG, 32'h0000_0000);
         chk(rd, iw);
         mk(h1);
         mk(h2);
         e1 = exp_res(c, h1);
         e2 = exp_res(c, h2);
         // two headers back to back
         go  <= 1'b1;
         req <= h1;
         @(posedge sys_clk);
         req <= h2;
         @(posedge sys_clk);
         go  <= 1'b0;
         @(posedge sys_clk);
         chk(32'(result_out), 32'(e1));
         @(posedge sys_clk);
         chk(32'(result_out), 32'(e2));
         // saturating count is the easy place for an off-by-one
         cnt = (cnt + e1.hit > 2 ** CW - 1) ? 2 ** CW - 1 : cnt + e1.hit;
         cnt = (cnt + e2.hit > 2 ** CW - 1) ? 2 ** CW - 1 : cnt + e2.hit;
         bus(1'b0, ADDR_STATUS, 32'h0000_0000);
         chk(rd, (32'(cnt) << ST_CNT_LSB) | {31'h0, e2.hit});
      end
      $display("test random frames done");
      conclude();
   end
endmodule : tb_top
